// File: pkg/lpsc_params.svh
/*
  Timing and encoding constants for the low-power state controller.
  Assumes inclusion by bare name from the package file; the design files only use its macros.
*/
`ifndef LPSC_PARAMS_SVH
`define LPSC_PARAMS_SVH

`define LPSC_SYNC_STAGES     2
`define LPSC_RELEASE_CLKS    2
`define LPSC_RELEASE_W       2
`define LPSC_STRAP_W         2
`define LPSC_GATE_W          3
`define LPSC_GATE_ALL        3'h7
`define LPSC_GATE_BUS_IRQ    3'h6
`define LPSC_GATE_NONE       3'h0
`define LPSC_GATE_CORE_BIT   0
`define LPSC_GATE_IRQ_BIT    1
`define LPSC_GATE_BUS_BIT    2
`define LPSC_ACK_W           2
`define LPSC_ACK_NONE        2'h0
`define LPSC_ACK_STOP_GRANT  2'h1
`define LPSC_ACK_MGMT        2'h2

`endif

// File: pkg/lpsc_pkg.sv
/*
  Types for the low-power state controller.
  Assumes lpsc_params.svh is on the include path.
*/
`include "lpsc_params.svh"

package lpsc_pkg;

  typedef enum logic [2:0] {
    LPSC_NORMAL,
    LPSC_STOP_GRANT,
    LPSC_SLEEP,
    LPSC_DEEP_SLEEP
  } lpsc_state_t;

endpackage : lpsc_pkg

// File: hw/lpsc_sync.sv
/*
  Two-flop synchroniser bank for the asynchronous power-state inputs.
  Assumes inputs are levels; a freeze holds both stages.
*/
`timescale 1ns/1ps
`default_nettype none

module lpsc_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic             clk_en,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1;

  // Reset value is all ones: the inputs are active low, so idle reads inactive
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always_ff @(posedge sys_clk) begin
        if (reset) begin
          stage1[i]   <= 1'b1;
          sync_out[i] <= 1'b1;
        end else if (clk_en) begin
          stage1[i]   <= async_in[i];
          sync_out[i] <= stage1[i];
        end
      end
    end
  endgenerate

endmodule : lpsc_sync

`default_nettype wire

// File: hw/lpsc_ctrl.sv
/*
  Low-power state controller: sequences Normal, Stop-Grant, Sleep and Deep
  Sleep, gates unit clocks, requests acknowledge bus cycles and enters
  management mode on a management interrupt.
  Assumes the bus interface turns each ack_req, held until ack_done, into one bus transaction and
  that the core honours the clock gate and handler-start outputs.
*/
`timescale 1ns/1ps
`default_nettype none

module lpsc_ctrl
  import lpsc_pkg::*;
(
  input  wire logic                     sys_clk,
  input  wire logic                     reset,
  input  wire logic                     clk_en,
  input  wire logic                     clock_halt_req_n,
  input  wire logic                     doze_req_n,
  input  wire logic                     deep_doze_req_n,
  input  wire logic                     mgmt_irq_n,
  input  wire logic                     bus_clk_present,
  input  wire logic                     snoop_req,
  input  wire logic                     irq_req,
  input  wire logic                     ack_done,
  input  wire logic                     mgmt_exit,
  output logic      [`LPSC_GATE_W-1:0]  unit_clk_en,
  output logic                          ack_req,
  output logic      [`LPSC_ACK_W-1:0]   ack_type,
  output logic                          snoop_accept,
  output logic                          irq_accept,
  output logic                          exec_run,
  output logic                          state_save,
  output logic                          system_mgmt_mode,
  output logic                          handler_start,
  output logic                          power_status_ind_n,
  output logic                          bus_out_oe_n,
  output logic                          pins_tristate,
  output logic      [2:0]               power_state
);

  logic [3:0]  sync_in;
  logic        halt_req;
  logic        doze_req;
  logic        deep_req;
  logic        mgmt_req;
  logic        mgmt_seen;
  logic        reset_d;
  logic        mgmt_pend;
  logic        mgmt_take;
  logic        mgmt_wait_ack;
  logic        ack_busy;
  logic [`LPSC_RELEASE_W-1:0] release_cnt;
  logic [`LPSC_STRAP_W-1:0]   strap_cnt;
  lpsc_state_t state;
  lpsc_state_t next_state;

  // Only the second stage feeds the state logic; bus clock itself is untouched
  lpsc_sync #(
    .WIDTH (4)
  ) u_sync (
    .sys_clk  (sys_clk),
    .reset    (reset),
    .clk_en   (clk_en),
    .async_in ({mgmt_irq_n, deep_doze_req_n, doze_req_n, clock_halt_req_n}),
    .sync_out (sync_in)
  );

  assign halt_req = ~sync_in[0];
  assign doze_req = ~sync_in[1];
  assign deep_req = ~sync_in[2];
  assign mgmt_req = ~sync_in[3];

  always_comb begin
    next_state = state;
    case (state)
      LPSC_NORMAL: begin
        if (halt_req && !mgmt_wait_ack) begin
          next_state = LPSC_STOP_GRANT;
        end
      end
      LPSC_STOP_GRANT: begin
        if (doze_req) begin
          next_state = LPSC_SLEEP;
        end else if (!halt_req) begin
          next_state = LPSC_NORMAL;
        end
      end
      LPSC_SLEEP: begin
        // Only sleep release and deep-sleep move this state
        if (!doze_req) begin
          next_state = LPSC_STOP_GRANT;
        end else if (deep_req) begin
          next_state = LPSC_DEEP_SLEEP;
        end
      end
      LPSC_DEEP_SLEEP: begin
        // Deep Sleep exit is assumed to step back to Sleep, never further
        if (!deep_req) begin
          next_state = LPSC_SLEEP;
        end
      end
      default: begin
        next_state = LPSC_NORMAL;
      end
    endcase
  end
  // Sleep asked for in Normal, or deep-sleep outside Sleep, has no arc

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= LPSC_NORMAL;
    end else if (clk_en) begin
      state <= next_state;
    end
  end

  // Reported in enum order, so the pin value matches the state numbering
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      power_state <= 3'h0;
    end else if (clk_en) begin
      power_state <= next_state;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      unit_clk_en <= `LPSC_GATE_ALL;
    end else if (clk_en) begin
      // Taken from next_state so the gates move on the same edge as the state
      case (next_state)
        LPSC_NORMAL: begin
          unit_clk_en <= `LPSC_GATE_ALL;
        end
        LPSC_STOP_GRANT: begin
          unit_clk_en <= `LPSC_GATE_BUS_IRQ;
        end
        default: begin
          unit_clk_en <= `LPSC_GATE_NONE;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      snoop_accept <= 1'b0;
      irq_accept   <= 1'b0;
      exec_run     <= 1'b1;
    end else if (clk_en) begin
      // Registered acceptance: a request is honoured one edge after it is seen
      snoop_accept <= snoop_req && (state == LPSC_NORMAL || state == LPSC_STOP_GRANT);
      irq_accept   <= irq_req && (state == LPSC_NORMAL || state == LPSC_STOP_GRANT);
      // Execution stays halted while the management acknowledge is outstanding
      exec_run     <= (next_state == LPSC_NORMAL) && !mgmt_wait_ack;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      power_status_ind_n <= 1'b1;
    end else if (clk_en) begin
      power_status_ind_n <= (next_state != LPSC_DEEP_SLEEP);
    end
  end

  // Management interrupt is a falling edge, taken only while executing in Normal
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mgmt_seen <= 1'b0;
    end else if (clk_en) begin
      mgmt_seen <= mgmt_req;
    end
  end

  // A stop-clock request in the same cycle wins; the interrupt stays pending
  assign mgmt_take = mgmt_pend && (state == LPSC_NORMAL) && (next_state == LPSC_NORMAL)
                     && !system_mgmt_mode && !ack_busy;

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      mgmt_pend <= 1'b0;
    end else if (clk_en) begin
      // A level held across reset release is the strap, not an interrupt
      if (mgmt_req && !mgmt_seen && !reset_d) begin
        mgmt_pend <= 1'b1;
      end else if (mgmt_take) begin
        mgmt_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      system_mgmt_mode <= 1'b0;
      state_save       <= 1'b0;
      mgmt_wait_ack    <= 1'b0;
      handler_start    <= 1'b0;
    end else if (clk_en) begin
      // Save and handler start are single-cycle strobes
      state_save    <= 1'b0;
      handler_start <= 1'b0;
      if (mgmt_take) begin
        system_mgmt_mode <= 1'b1;
        state_save       <= 1'b1;
        mgmt_wait_ack    <= 1'b1;
      end else if (mgmt_wait_ack && ack_busy && ack_done && ack_type == `LPSC_ACK_MGMT) begin
        mgmt_wait_ack <= 1'b0;
        handler_start <= 1'b1;
      end else if (system_mgmt_mode && !mgmt_wait_ack && mgmt_exit) begin
        system_mgmt_mode <= 1'b0;
      end
    end
  end

  // Acknowledge cycle request holds until the bus interface reports it done
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_req  <= 1'b0;
      ack_type <= `LPSC_ACK_NONE;
      ack_busy <= 1'b0;
    end else if (clk_en) begin
      if (ack_busy) begin
        if (ack_done) begin
          ack_req  <= 1'b0;
          ack_type <= `LPSC_ACK_NONE;
          ack_busy <= 1'b0;
        end
      end else if (state == LPSC_NORMAL && next_state == LPSC_STOP_GRANT) begin
        ack_req  <= 1'b1;
        ack_type <= `LPSC_ACK_STOP_GRANT;
        ack_busy <= 1'b1;
      end else if (mgmt_wait_ack) begin
        ack_req  <= 1'b1;
        ack_type <= `LPSC_ACK_MGMT;
        ack_busy <= 1'b1;
      end
    end
  end

  // The synchroniser reads idle right after release, so the strap is sampled
  // only once its stages hold the pin's real level
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      strap_cnt <= `LPSC_STRAP_W'(`LPSC_SYNC_STAGES);
    end else if (clk_en) begin
      if (strap_cnt != `LPSC_STRAP_W'(0)) begin
        strap_cnt <= strap_cnt - `LPSC_STRAP_W'(1);
      end
    end
  end

  // Reset strap of the management input is caught once, when the window closes
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      reset_d       <= 1'b1;
      pins_tristate <= 1'b0;
    end else if (clk_en) begin
      if (reset_d && strap_cnt == `LPSC_STRAP_W'(0)) begin
        reset_d       <= 1'b0;
        pins_tristate <= mgmt_req;
      end
    end
  end

  // Output enable drops one edge into reset, well inside the two-clock limit
  // Outputs stay released until the strap is known, so a strapped part never drives
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      bus_out_oe_n <= 1'b1;
      release_cnt  <= `LPSC_RELEASE_W'(`LPSC_RELEASE_CLKS);
    end else if (clk_en) begin
      if (release_cnt != `LPSC_RELEASE_W'(0)) begin
        release_cnt <= release_cnt - `LPSC_RELEASE_W'(1);
      end
      bus_out_oe_n <= pins_tristate || reset_d || !bus_clk_present ||
                      (release_cnt != `LPSC_RELEASE_W'(0));
    end
  end

endmodule : lpsc_ctrl

`default_nettype wire

// File: tb/lpsc_ctrl_monitor.sv
/*
  Concurrent checks on the lpsc_ctrl ports.
  Assumes clk_en stays high and a bind by port name.
*/
`timescale 1ns/1ps
`default_nettype none
module lpsc_ctrl_monitor (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       clock_halt_req_n,
  input wire logic       doze_req_n,
  input wire logic       snoop_req,
  input wire logic       irq_req,
  input wire logic       ack_done,
  input wire logic       ack_req,
  input wire logic [1:0] ack_type,
  input wire logic       snoop_accept,
  input wire logic       irq_accept,
  input wire logic [2:0] unit_clk_en,
  input wire logic       handler_start,
  input wire logic       power_status_ind_n,
  input wire logic       bus_out_oe_n,
  input wire logic [2:0] power_state,
  input wire logic       state_save,
  input wire logic       system_mgmt_mode,
  input wire logic       pins_tristate
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sequence s_halt_in;
    $fell(clock_halt_req_n) && power_state == 3'h0 && !ack_req;
  endsequence
  sequence s_wake_in;
    $rose(clock_halt_req_n) && power_state == 3'h1 && doze_req_n;
  endsequence
  a_halt_enters_sg: assert property (s_halt_in |-> ##[1:3] power_state == 3'h1)
    else $error("stop-grant not entered");
  a_sg_ack_sent: assert property (power_state == 3'h1 && $past(power_state) == 3'h0 |=> ack_req && ack_type == 2'h1)
    else $error("stop-grant ack missing");
  a_sg_core_gated: assert property (power_state == 3'h1 |-> unit_clk_en == 3'h6)
    else $error("stop-grant gating wrong");
  a_sg_snoop_kept: assert property (snoop_req && power_state <= 3'h1 |=> snoop_accept)
    else $error("snoop not accepted");
  a_wake_runs_all: assert property (s_wake_in |-> ##[1:3] (power_state == 3'h0 && unit_clk_en == 3'h7))
    else $error("clocks not restarted");
  a_sleep_no_clk: assert property (power_state >= 3'h2 |-> unit_clk_en == 3'h0)
    else $error("clocks run in sleep");
  a_sleep_deaf: assert property (power_state == 3'h2 && $past(power_state) == 3'h2 |-> !snoop_accept && !irq_accept)
    else $error("request accepted in sleep");
  a_doze_order: assert property ($fell(doze_req_n) && power_state == 3'h0 |-> (power_state != 3'h2) [*4])
    else $error("sleep entered from normal");
  a_deep_ind: assert property (power_status_ind_n == (power_state != 3'h3))
    else $error("status indicator wrong");
  a_ack_holds: assert property (ack_req && !ack_done |=> ack_req)
    else $error("ack request dropped");
  a_mgmt_handler: assert property (ack_req && ack_done && ack_type == 2'h2 |=> handler_start)
    else $error("handler not started");
  a_reset_release: assert property (disable iff (1'b0) reset |-> ##[1:2] bus_out_oe_n)
    else $error("bus outputs not released");
  a_strap_tristate: assert property (pins_tristate |-> bus_out_oe_n)
    else $error("strapped part drives bus");
  a_mgmt_saves: assert property ($rose(system_mgmt_mode) |-> state_save)
    else $error("state not saved on mgmt entry");
endmodule : lpsc_ctrl_monitor
bind lpsc_ctrl lpsc_ctrl_monitor u_mon (.*);
`default_nettype wire

// File: tb/lpsc_chipset_model.sv
/*
  Chipset model: drives the power-state pins and answers ack cycles.
  Assumes req bits are active-high commands from the bench.
*/
`timescale 1ns/1ps
`default_nettype none
module lpsc_chipset_model (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic [3:0] req,
  input  wire logic [3:0] ack_lat,
  input  wire logic       ack_req,
  output logic            clock_halt_req_n,
  output logic            doze_req_n,
  output logic            deep_doze_req_n,
  output logic            mgmt_irq_n,
  output logic            ack_done
);
  logic [3:0] cnt;
  assign clock_halt_req_n = ~req[0];
  assign doze_req_n = ~req[1];
  assign deep_doze_req_n = ~req[2];
  assign mgmt_irq_n = ~req[3];
  // Latency set by the bench, so both prompt and slow acks occur
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      ack_done <= 1'b0;
    end else begin
      ack_done <= ack_req && !ack_done && (cnt == ack_lat);
    end
  end
  always_ff @(posedge sys_clk) begin
    if (reset || !ack_req || ack_done || cnt == ack_lat) begin
      cnt <= 4'h0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule : lpsc_chipset_model
`default_nettype wire

// File: tb/tb_lpsc_ctrl.sv
/*
  Self-checking bench for lpsc_ctrl with the chipset model.
  Assumes the package and monitor are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_lpsc_ctrl;
  logic sys_clk = 1'b0, reset = 1'b1, clk_en = 1'b1, bus_clk_present = 1'b1;
  logic snoop_req = 1'b0, irq_req = 1'b0, mgmt_exit = 1'b0;
  logic [3:0] req = 4'h0, ack_lat = 4'h0;
  logic clock_halt_req_n, doze_req_n, deep_doze_req_n, mgmt_irq_n, ack_done, ack_req, snoop_accept;
  logic irq_accept, exec_run, state_save, system_mgmt_mode, handler_start, power_status_ind_n;
  logic bus_out_oe_n, pins_tristate;
  logic [2:0] unit_clk_en, power_state;
  logic [1:0] ack_type;
  int fail_count = 0, total_checks = 0, cyc = 0;
  always #5 sys_clk = ~sys_clk;
  lpsc_ctrl u_dut (
    .sys_clk            (sys_clk),
    .reset              (reset),
    .clk_en             (clk_en),
    .clock_halt_req_n   (clock_halt_req_n),
    .doze_req_n         (doze_req_n),
    .deep_doze_req_n    (deep_doze_req_n),
    .mgmt_irq_n         (mgmt_irq_n),
    .bus_clk_present    (bus_clk_present),
    .snoop_req          (snoop_req),
    .irq_req            (irq_req),
    .ack_done           (ack_done),
    .mgmt_exit          (mgmt_exit),
    .unit_clk_en        (unit_clk_en),
    .ack_req            (ack_req),
    .ack_type           (ack_type),
    .snoop_accept       (snoop_accept),
    .irq_accept         (irq_accept),
    .exec_run           (exec_run),
    .state_save         (state_save),
    .system_mgmt_mode   (system_mgmt_mode),
    .handler_start      (handler_start),
    .power_status_ind_n (power_status_ind_n),
    .bus_out_oe_n       (bus_out_oe_n),
    .pins_tristate      (pins_tristate),
    .power_state        (power_state)
  );
  lpsc_chipset_model u_chip (
    .sys_clk          (sys_clk),
    .reset            (reset),
    .req              (req),
    .ack_lat          (ack_lat),
    .ack_req          (ack_req),
    .clock_halt_req_n (clock_halt_req_n),
    .doze_req_n       (doze_req_n),
    .deep_doze_req_n  (deep_doze_req_n),
    .mgmt_irq_n       (mgmt_irq_n),
    .ack_done         (ack_done)
  );
  task step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : step
  task chk(input logic [3:0] got, input logic [3:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task ws(input logic [2:0] s);
    for (int i = 0; i < 8 && power_state !== s; i++) step(1);
    chk({1'b0, power_state}, {1'b0, s});
  endtask : ws
  task automatic wb(ref logic s);
    for (int i = 0; i < 12 && s !== 1'b1; i++) step(1);
    chk({3'h0, s}, 4'h1);
  endtask : wb
  task t_grant;
    req = 4'h2;
    step(5);
    chk({1'b0, power_state}, 4'h0);
    req = 4'h1;
    ws(3'h1);
    chk({exec_run, unit_clk_en}, 4'h6);
    wb(ack_req);
    chk({2'h0, ack_type}, 4'h1);
    snoop_req = 1;
    irq_req = 1;
    step(1);
    chk({2'h0, snoop_accept, irq_accept}, 4'h3);
    snoop_req = 0;
    irq_req = 0;
    req = 4'h5;
    step(5);
    chk({1'b0, power_state}, 4'h1);
    $display("test grant done");
  endtask : t_grant
  task t_sleep;
    req = 4'h3;
    ws(3'h2);
    chk({1'b0, unit_clk_en}, 4'h0);
    snoop_req = 1;
    step(2);
    chk({3'h0, snoop_accept}, 4'h0);
    snoop_req = 0;
    req = 4'h2;
    step(5);
    chk({1'b0, power_state}, 4'h2);
    req = 4'h7;
    ws(3'h3);
    chk({3'h0, power_status_ind_n}, 4'h0);
    req = 4'h3;
    ws(3'h2);
    chk({3'h0, power_status_ind_n}, 4'h1);
    req = 4'h1;
    ws(3'h1);
    chk({1'b0, unit_clk_en}, 4'h6);
    req = 4'h0;
    ws(3'h0);
    chk({exec_run, unit_clk_en}, 4'hf);
    $display("test sleep done");
  endtask : t_sleep
  task t_mgmt;
    ack_lat = 4'h5;
    req = 4'h8;
    wb(system_mgmt_mode);
    chk({3'h0, state_save}, 4'h1);
    wb(ack_req);
    chk({exec_run, handler_start, ack_type}, 4'h2);
    wb(handler_start);
    req = 4'h0;
    mgmt_exit = 1;
    step(1);
    mgmt_exit = 0;
    step(3);
    chk({exec_run, 2'h0, system_mgmt_mode}, 4'h8);
    $display("test mgmt done");
  endtask : t_mgmt
  task t_reset;
    req = 4'h8;
    reset = 1;
    step(3);
    reset = 0;
    step(4);
    chk({2'h0, pins_tristate, bus_out_oe_n}, 4'h3);
    req = 4'h0;
    reset = 1;
    step(3);
    reset = 0;
    step(4);
    chk({2'h0, pins_tristate, bus_out_oe_n}, 4'h0);
    bus_clk_present = 0;
    step(2);
    chk({3'h0, bus_out_oe_n}, 4'h1);
    bus_clk_present = 1;
    step(2);
    chk({3'h0, bus_out_oe_n}, 4'h0);
    $display("test reset done");
  endtask : t_reset
  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : end_sim
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      $display("ERROR %0t: timeout", $time);
      end_sim();
    end
  end
  initial begin
    step(3);
    reset = 0;
    step(1);
    t_grant();
    t_sleep();
    t_mgmt();
    t_reset();
    end_sim();
  end
endmodule : tb_lpsc_ctrl
`default_nettype wire
